// ===== hw/embi_ctrl.sv
// External static-memory bus controller with hold arbitration.
`timescale 1ns/100ps
`include "embi_defs.svh"
module embi_ctrl #(
    parameter int ADDR_W = `EMBI_ADDR_W,
    parameter int DATA_W = `EMBI_DATA_W,
    parameter int BANKS = `EMBI_BANKS
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Boot strap
    input wire logic [1:0] i_boot_mode_pins,
    output logic o_nand_boot,
    output logic o_test_mode,
    // Bank configuration, flattened per bank
    input wire logic [BANKS*2-1:0] i_bank_width,
    input wire logic [BANKS*`EMBI_CYC_W-1:0] i_bank_cycles,
    input wire logic [BANKS*3-1:0] i_bank_size,
    // Internal request port
    input wire logic i_req_valid,
    input wire embi_pkg::embi_req_s i_req,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [DATA_W-1:0] o_rsp_rdata,
    // External bus pins
    output logic [ADDR_W-1:0] o_addr,
    output logic o_addr_oe,
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data,
    output logic [DATA_W-1:0] o_data_oe,
    output logic [BANKS-1:0] o_bank_select_n,
    output logic o_write_strobe_n,
    output logic o_read_strobe_n,
    output logic [3:0] o_byte_lane_enable_n,
    input wire logic i_cycle_extend_n,
    input wire logic i_hold_request_n,
    output logic o_hold_grant_n
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_FINISH,
        ST_HOLD
    } embi_state_e;
    typedef struct packed {
        embi_state_e state;
        logic [1:0] boot;
        logic booted;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] ben;
        logic write;
        logic [2:0] bank;
        logic [1:0] width;
        logic [`EMBI_CYC_W-1:0] cnt;
        logic [DATA_W-1:0] rdata;
        logic rsp;
    } embi_st_s;
    embi_st_s st_q;
    embi_st_s st_d;
    logic extend_n;
    logic hold_req_n;
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    embi_sync #(.RESET_VAL(1'b1)) u_sync_wait (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_pin(i_cycle_extend_n),
        .o_level(extend_n)
    );
    embi_sync #(.RESET_VAL(1'b1)) u_sync_hold (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_pin(i_hold_request_n),
        .o_level(hold_req_n)
    );
    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // Bank index from the top address bits.
    function automatic logic [2:0] bank_of(input logic [ADDR_W-1:0] a);
        bank_of = a[`EMBI_BANK_SEL_LSB+:3];
    endfunction
    // Bank 0 width follows the strap; others follow configuration.
    function automatic logic [1:0] width_of(input logic [2:0] b,
                                            input logic [1:0] boot);
        logic [1:0] w;
        w = i_bank_width[b*2+:2];
        if (b == 3'h0) begin
            case (boot)
                `EMBI_MODE_W16: w = `EMBI_WIDTH_16;
                `EMBI_MODE_W32: w = `EMBI_WIDTH_32;
                default: w = `EMBI_WIDTH_8;
            endcase
        end
        width_of = w;
    endfunction
    // Offset inside a bank must fit its programmed size (2^(17+n)).
    function automatic logic in_size(input logic [ADDR_W-1:0] a,
                                     input logic [2:0] b);
        logic [4:0] bits;
        logic [ADDR_W-1:0] lim;
        bits = 5'(17) + 5'(i_bank_size[b*3+:3]);
        lim = (bits >= 5'(`EMBI_BANK_SEL_LSB)) ? '1 :
              ((ADDR_W'(1) << bits) - ADDR_W'(1));
        in_size = ((a & ADDR_W'(24'hFFFFFF)) <= lim);
    endfunction
    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    logic [`EMBI_CYC_W-1:0] req_cyc;
    assign req_cyc = i_bank_cycles[bank_of(i_req.addr)*`EMBI_CYC_W+:
                                   `EMBI_CYC_W];
    always_comb begin
        st_d = st_q;
        st_d.rsp = 1'b0;
        if (!st_q.booted) begin
            st_d.boot = i_boot_mode_pins;
            st_d.booted = 1'b1;
        end
        case (st_q.state)
            ST_IDLE: begin
                if (!hold_req_n) begin
                    st_d.state = ST_HOLD;
                end else if (i_req_valid && st_q.booted) begin
                    st_d.state = ST_ACCESS;
                    st_d.addr = i_req.addr;
                    st_d.wdata = i_req.wdata;
                    st_d.write = i_req.write;
                    st_d.bank = bank_of(i_req.addr);
                    st_d.width = width_of(bank_of(i_req.addr), st_q.boot);
                    st_d.ben = i_req.be;
                    st_d.cnt = (req_cyc < `EMBI_MIN_CYC) ?
                               `EMBI_MIN_CYC : req_cyc;
                end
            end
            ST_ACCESS: begin
                if (st_q.cnt > `EMBI_MIN_CYC) begin
                    st_d.cnt = st_q.cnt - `EMBI_MIN_CYC;
                end else if (extend_n) begin
                    st_d.state = ST_FINISH;
                    st_d.rdata = i_data;
                end
            end
            ST_FINISH: begin
                st_d.rsp = 1'b1;
                st_d.state = ST_IDLE;
            end
            ST_HOLD: begin
                if (hold_req_n) begin
                    st_d.state = ST_IDLE;
                end
            end
            default: st_d.state = ST_IDLE;
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end
    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    logic active;
    logic hit;
    assign active = (st_q.state == ST_ACCESS);
    assign hit = in_size(st_q.addr, st_q.bank);
    always_comb begin
        o_bank_select_n = '1;
        if (active && hit) begin
            o_bank_select_n[st_q.bank] = 1'b0;
        end
    end
    // A write and a read are never in flight together.
    assign o_write_strobe_n = !(active && hit && st_q.write);
    assign o_read_strobe_n = !(active && hit && !st_q.write);
    always_comb begin
        o_byte_lane_enable_n = '1;
        if (active) begin
            case (st_q.width)
                `EMBI_WIDTH_16: o_byte_lane_enable_n = {2'h3,
                                                       ~st_q.ben[1:0]};
                `EMBI_WIDTH_32: o_byte_lane_enable_n = ~st_q.ben;
                default: o_byte_lane_enable_n = 4'hE;
            endcase
        end
    end
    assign o_addr = st_q.addr;
    // Address floats only while granted.
    assign o_addr_oe = (st_q.state != ST_HOLD);
    always_comb begin
        o_data = st_q.wdata;
        o_data_oe = '0;
        if (active && st_q.write) begin
            case (st_q.width)
                `EMBI_WIDTH_8: o_data_oe = DATA_W'(8'hFF);
                `EMBI_WIDTH_16: o_data_oe = DATA_W'(16'hFFFF);
                default: o_data_oe = '1;
            endcase
        end
    end
    assign o_hold_grant_n = (st_q.state != ST_HOLD);
    assign o_req_ready = (st_q.state == ST_IDLE) && hold_req_n &&
                         st_q.booted;
    assign o_rsp_valid = st_q.rsp;
    assign o_rsp_rdata = st_q.rdata;
    assign o_nand_boot = (st_q.boot == `EMBI_MODE_NAND) && st_q.booted;
    assign o_test_mode = (st_q.boot == `EMBI_MODE_TEST);
endmodule // embi_ctrl

// ===== hw/embi_defs.svh
// Constants of the external memory bus interface.
`ifndef EMBI_DEFS_SVH
`define EMBI_DEFS_SVH
`define EMBI_MODE_NAND 2'h0
`define EMBI_MODE_W16 2'h1
`define EMBI_MODE_W32 2'h2
`define EMBI_MODE_TEST 2'h3
`define EMBI_ADDR_W 27
`define EMBI_DATA_W 32
`define EMBI_BANKS 8
`define EMBI_BANK_SEL_LSB 24
`define EMBI_WIDTH_8 2'h0
`define EMBI_WIDTH_16 2'h1
`define EMBI_WIDTH_32 2'h2
`define EMBI_CYC_W 4
`define EMBI_MIN_CYC 4'h1
`endif

// ===== hw/embi_pkg.sv
// Types of the external memory bus interface.
package embi_pkg;
    typedef enum logic [1:0] {
        BOOT_NAND,
        BOOT_W16,
        BOOT_W32,
        BOOT_TEST
    } embi_boot_e;
    typedef struct packed {
        logic [26:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic write;
    } embi_req_s;
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stab;
    } embi_sync_s;
endpackage

// ===== hw/embi_sync.sv
// Three-flop input synchroniser with agreement filter.
`timescale 1ns/100ps
`include "embi_defs.svh"
module embi_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed {
        logic [2:0] ff;
        logic lvl;
    } embi_sync_st_s;
    embi_sync_st_s st_q;
    embi_sync_st_s st_d;
    always_comb begin
        st_d = st_q;
        st_d.ff = {st_q.ff[1:0], i_pin};
        // Only the second and third stages are compared.
        if (st_q.ff[1] == st_q.ff[2]) begin
            st_d.lvl = st_q.ff[2];
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= {{3{RESET_VAL}}, RESET_VAL};
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end
    assign o_level = st_q.lvl;
endmodule // embi_sync

// ===== sim/embi_ctrl_assertions.sv
// Port checker for the external memory bus controller.
`timescale 1ns/100ps
module embi_ctrl_checker #(
    parameter int ADDR_W = 27,
    parameter int DATA_W = 32,
    parameter int BANKS = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Watched pins
    input wire logic i_cycle_extend_n,
    input wire logic i_hold_request_n,
    input wire logic o_hold_grant_n,
    input wire logic o_addr_oe,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic [DATA_W-1:0] o_data_oe,
    input wire logic [BANKS-1:0] o_bank_select_n,
    input wire logic o_write_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic o_rsp_valid
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    wire logic we = !o_write_strobe_n;
    wire logic re = !o_read_strobe_n;
    a_strobe_excl: assert property (!(we && re))
        else $error("both strobes low");
    a_write_drives: assert property (we |-> o_data_oe != '0)
        else $error("write strobe without driven data");
    a_read_floats: assert property (re |-> o_data_oe == '0)
        else $error("read strobe while driving data");
    a_grant_float: assert property (!o_hold_grant_n |->
        !o_addr_oe && o_data_oe == '0 && &o_bank_select_n && !we && !re)
        else $error("bus not released while granted");
    a_one_select: assert property ($countones(~o_bank_select_n) <= 1)
        else $error("several bank selects low");
    a_select_bank: assert property (!(&o_bank_select_n) |->
        !o_bank_select_n[o_addr[26:24]])
        else $error("bank select does not match address");
    a_extend_stall: assert property (!i_cycle_extend_n [*7] |->
        !o_rsp_valid)
        else $error("cycle ended while extend held low");
    a_hold_synced: assert property ($fell(i_hold_request_n) &&
        o_hold_grant_n |=> o_hold_grant_n [*2])
        else $error("grant too soon after request");
    a_grant_drop: assert property (i_hold_request_n [*8] |->
        o_hold_grant_n)
        else $error("grant held without request");
    a_rsp_idle: assert property (o_rsp_valid |-> !we && !re)
        else $error("strobe low in response cycle");
endmodule // embi_ctrl_checker

bind embi_ctrl embi_ctrl_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
    .BANKS(BANKS)) u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_cycle_extend_n(i_cycle_extend_n), .o_addr(o_addr),
    .i_hold_request_n(i_hold_request_n), .o_hold_grant_n(o_hold_grant_n),
    .o_addr_oe(o_addr_oe), .o_data_oe(o_data_oe), .o_rsp_valid(o_rsp_valid),
    .o_bank_select_n(o_bank_select_n), .o_write_strobe_n(o_write_strobe_n),
    .o_read_strobe_n(o_read_strobe_n));

// ===== sim/embi_mem_model.sv
// Behavioural static memory behind the controller's bus pins.
`timescale 1ns/100ps
module embi_mem_model (
    // Clock and wait length
    input wire logic i_ref_clk,
    input wire logic [3:0] i_wait,
    // Bus from the controller
    input wire logic [26:0] i_addr,
    input wire logic [31:0] i_data,
    input wire logic [31:0] i_data_oe,
    input wire logic [7:0] i_bank_select_n,
    input wire logic i_write_strobe_n,
    input wire logic i_read_strobe_n,
    // Answers
    output logic [31:0] o_data,
    output logic o_cycle_extend_n = 1'b1
);
    logic [31:0] mem [16];
    logic [3:0] cnt = 4'h0;
    logic strb_q = 1'b0;
    wire logic strb = !(&i_bank_select_n) &&
        !(i_write_strobe_n && i_read_strobe_n);
    wire logic [3:0] ix = i_addr[5:2];
    always @(posedge i_ref_clk) begin
        strb_q <= strb;
        if (strb && !strb_q && i_wait != 4'h0) begin
            cnt <= i_wait;
            o_cycle_extend_n <= 1'b0;
        end else if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
        end else begin
            cnt <= 4'h0;
            o_cycle_extend_n <= 1'b1;
        end
        if (strb && !i_write_strobe_n) begin
            mem[ix] <= (mem[ix] & ~i_data_oe) | (i_data & i_data_oe);
        end
    end
    // Released data lines rest at the pad pull-up level, not at old data.
    assign o_data = (strb && !i_read_strobe_n) ? mem[ix] : '1;
endmodule // embi_mem_model

// ===== sim/tb.sv
// Self-checking bench for the external memory bus controller.
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0, nrst = 1'b0, vld = 1'b0, hreq_n = 1'b1;
    logic [1:0] strap = 2'h2;
    logic [3:0] wt = 4'h0;
    embi_pkg::embi_req_s req = '0;
    int failures = 0, check_count = 0, cyc = 0, st;
    logic rdy, rv, nand_b, tst, aoe, we_n, re_n, ext_n, gnt_n;
    logic [31:0] rdat, dout, doe, din, r;
    logic [26:0] addr;
    logic [7:0] sel_n, s;
    logic [3:0] ben, l;
    always #5 clk = ~clk;
    embi_ctrl i_embi_ctrl (.i_ref_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
        .i_boot_mode_pins(strap), .o_nand_boot(nand_b), .o_test_mode(tst),
        .i_bank_width(16'hAA84), .i_bank_cycles(32'h76543210),
        .i_bank_size(24'hFFF1FF), .i_req_valid(vld), .i_req(req),
        .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(rdat),
        .o_addr(addr), .o_addr_oe(aoe), .i_data(din), .o_data(dout),
        .o_data_oe(doe), .o_bank_select_n(sel_n), .o_write_strobe_n(we_n),
        .o_read_strobe_n(re_n), .o_byte_lane_enable_n(ben),
        .i_cycle_extend_n(ext_n), .i_hold_request_n(hreq_n),
        .o_hold_grant_n(gnt_n));
    embi_mem_model u_mem (.i_ref_clk(clk), .i_wait(wt), .i_addr(addr),
        .i_data(dout), .i_data_oe(doe), .i_bank_select_n(sel_n),
        .i_write_strobe_n(we_n), .i_read_strobe_n(re_n), .o_data(din),
        .o_cycle_extend_n(ext_n));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic rst(input logic [1:0] m);
        nrst <= 1'b0;
        strap <= m;
        repeat (12) @(posedge clk);
        chk({we_n, re_n, gnt_n, sel_n}, 32'h7FF);
        chk(addr, 32'h0);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic acc(input logic [26:0] a, input logic [31:0] d,
            input logic [3:0] b, input logic w);
        st = 0;
        s = 8'hFF;
        l = 4'hF;
        req <= '{addr: a, wdata: d, be: b, write: w};
        vld <= 1'b1;
        @(negedge clk);
        for (int n = 0; n < 60 && !rdy; n++) @(negedge clk);
        @(posedge clk);
        vld <= 1'b0;
        for (int n = 0; n < 80 && !rv; n++) begin
            @(negedge clk);
            if (!(we_n && re_n)) begin
                st++;
                s = sel_n;
                l = ben;
            end
        end
        r = rdat;
        @(posedge clk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_boot;
        for (int m = 0; m < 4; m++) begin
            rst(m[1:0]);
            chk({nand_b, tst}, {m == 0, m == 3});
        end
        rst(2'h1);
        acc(27'h10, 32'hA5A55A5A, 4'h6, 1'b1);
        chk(l, 4'hD);
        rst(2'h2);
        acc(27'h10, 32'hA5A55A5A, 4'h6, 1'b1);
        chk(l, 4'h9);
    endtask
    task automatic t_banks;
        logic [1:0] wd;
        logic [31:0] d, mk;
        for (int b = 0; b < 8; b++) begin
            wd = (b == 0) ? 2'h2 : 16'hAA84 >> (2 * b);
            mk = (wd == 2'h0) ? 32'hFF : (wd == 2'h1) ? 32'hFFFF : '1;
            d = 32'h11223344 ^ {8{b[3:0]}};
            acc({b[2:0], 24'h10}, d, 4'hF, 1'b1);
            chk(s, 8'(~(8'h01 << b)));
            chk(st, (b == 0) ? 1 : b);
            chk(l, (wd == 2'h0) ? 4'hE :
                   (wd == 2'h1) ? 4'hC : 4'h0);
            acc({b[2:0], 24'h10}, 32'h0, 4'hF, 1'b0);
            chk(r & mk, d & mk);
        end
    endtask
    task automatic t_size_wait;
        acc({3'h3, 24'h020000}, 32'h0, 4'hF, 1'b0);
        chk({st[7:0], s}, 16'h00FF);
        wt <= 4'hC;
        acc({3'h7, 24'h10}, 32'h0, 4'hF, 1'b0);
        chk(st > 7, 1'b1);
        chk(r, 32'h11223344 ^ {8{4'h7}});
        wt <= 4'h0;
    endtask
    task automatic t_hold;
        hreq_n <= 1'b0;
        for (int n = 0; n < 12 && gnt_n; n++) @(negedge clk);
        chk({gnt_n, aoe, rdy}, 32'h0);
        chk(doe, 32'h0);
        chk({sel_n, we_n, re_n}, 32'h3FF);
        @(posedge clk);
        hreq_n <= 1'b1;
        for (int n = 0; n < 12 && !gnt_n; n++) @(negedge clk);
        chk({gnt_n, aoe}, 2'h3);
    endtask
    initial begin
        t_boot();
        t_banks();
        t_size_wait();
        t_hold();
        conclude();
    end
endmodule // tb
